// File: common/plo_defines.svh
// Register map, field positions, reset values and timing counts.
`ifndef PLO_DEFINES_SVH
`define PLO_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PLO_ADDR_CTRL 8'h00
`define PLO_ADDR_DIVIDE 8'h04
`define PLO_ADDR_DIV_A 8'h08
`define PLO_ADDR_DIV_B 8'h0C
`define PLO_ADDR_DIV_E 8'h10
`define PLO_ADDR_STATUS 8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define PLO_CTRL_EXT_EN 0
`define PLO_CTRL_EXT_DIFF 1
`define PLO_CTRL_REF_DIFF 2
`define PLO_CTRL_MODE_LSB 3
`define PLO_CTRL_COMMON 5
`define PLO_CTRL_FB_TAP_LSB 8
`define PLO_CTRL_CTAP_LSB 12
`define PLO_CTRL_CINIT_LSB 16
`define PLO_N_LSB 0
`define PLO_M_LSB 8
`define PLO_HIGH_LSB 0
`define PLO_LOW_LSB 8
`define PLO_TAP_LSB 16
`define PLO_INIT_LSB 24

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define PLO_CTRL_MASK 32'h001F_773F
`define PLO_CTRL_RESET 32'h0000_0008
`define PLO_DIVIDE_RESET 32'h0000_0201
`define PLO_DIV_RESET 32'h0000_0101
`define PLO_N_MIN 6'h01
`define PLO_N_MAX 6'h20
`define PLO_M_MIN 6'h02
`define PLO_M_MAX 6'h20
`define PLO_HIGH_MIN 6'h01
`define PLO_LOW_MAX 6'h1F
`define PLO_RATIO_MAX 7'h20

// ****************************************************************
// Timing
// ****************************************************************
`define PLO_CLK_PERIOD_PS 5000
`define PLO_TAP_MIN_PS 125
`define PLO_TAP_MIN_CYC_I ((`PLO_TAP_MIN_PS + `PLO_CLK_PERIOD_PS - 1) \
   / `PLO_CLK_PERIOD_PS)
`define PLO_TAP_MIN_CYC (`PLO_TAP_MIN_CYC_I < 1 ? 1 : `PLO_TAP_MIN_CYC_I)
`define PLO_STEP_MAX 8'h40
`define PLO_STEP_RESET 8'h08
`define PLO_LOCK_GOOD 4'h8
`define PLO_REF_TIMEOUT 12'hFA0
`define PLO_EXT_COMP_TAPS 3'h2
`define PLO_INT_COMP_TAPS 3'h5

`endif

// File: common/plo_pkg.sv
// Types shared by the loop control design.
package plo_pkg;

   typedef enum logic [1:0] {
      COMP_ZERO_DELAY,
      COMP_NORMAL,
      COMP_NONE
   } plo_comp_type;

   typedef enum logic [1:0] {
      LOOP_OFF,
      LOOP_ACQUIRE,
      LOOP_LOCKED
   } plo_loop_type;

endpackage : plo_pkg

// File: hdl/plo_divider.sv
// Post-scale divider with separate high and low counts.
`timescale 1ns/10ps
module plo_divider (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Control
   input wire logic clear,
   input wire logic tick,
   input wire logic [5:0] high_cnt,
   input wire logic [5:0] low_cnt,
   input wire logic [5:0] init_cnt,
   // Divided clock
   output logic clk_out
);

   logic [5:0] cnt;
   logic [6:0] ratio;
   logic [6:0] next_cnt;

   assign ratio = {1'b0, high_cnt} + {1'b0, low_cnt};
   assign next_cnt = ({1'b0, cnt} + 7'h01 >= ratio) ? 7'h00
                     : {1'b0, cnt} + 7'h01;

   // An initial count at or beyond the ratio is not kept, so it starts at 0.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= 6'h00;
         clk_out <= 1'b0;
      end else if (clear) begin
         cnt <= ({1'b0, init_cnt} < ratio) ? init_cnt : 6'h00;
         clk_out <= 1'b0;
      end else if (tick) begin
         cnt <= next_cnt[5:0];
         clk_out <= (next_cnt < {1'b0, high_cnt}); // [RULE24] [RULE12]
      end
   end

endmodule : plo_divider

// File: hdl/plo_top.sv
// Loop control: reference select, oscillator taps, dividers, lock, APB.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/10ps
`include "plo_defines.svh"

// Overview of operation
// [RULE1] Reference taken from clock pins, single or differential.
// [RULE2] One external output; unused pins act as GPIO.
// [RULE3] Zero delay mode aligns external output to reference.
// [RULE4] Normal mode compensates internal output delay.
// [RULE5] No compensation mode applies no offset.
// [RULE6] Shift set per output or common to all.
// [RULE7] Finest shift step is one eighth oscillator period.
// [RULE8] Each output picks tap and initial count.
// [RULE9] Feedback tap shifts every output equally.
// [RULE10] Lock only while stable and in phase.
// [RULE11] User logic should filter lock before use.
// [RULE12] Each divider has high and low counts.
// [RULE13] Run enable low grounds outputs, drops lock.
// [RULE14] Run enable high again relocks and resynchronizes.
// [RULE15] Run enable comes from pin or logic.
// [RULE16] Resync high resets counters, outputs, lock.
// [RULE17] Resync released low resynchronizes and relocks.
// [RULE18] Gate off holds oscillator setting, outputs keep running.
// [RULE19] User logic drives detector gate as it likes.
// [RULE20] Oscillator runs at input times m over n.
// [RULE21] Pre-scale n ranges 1 to 32.
// [RULE22] Multiply m ranges 2 to 32.
// [RULE23] Output dividers range 1 to 32.
// [RULE24] Divider high then low counts sum to ratio.
module plo_top import plo_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reference clock pins
   input wire logic ref_clk_p,
   input wire logic ref_clk_n,
   // Loop controls
   input wire logic run_enable,
   input wire logic counter_resync,
   input wire logic detector_gate_enable,
   // Internal clock outputs and lock
   output logic global_clock_a,
   output logic global_clock_b,
   output logic lock,
   // External output pins
   input wire logic ext_p_in,
   output logic ext_p_out,
   output logic ext_p_oe_n,
   input wire logic ext_n_in,
   output logic ext_n_out,
   output logic ext_n_oe_n,
   // General-purpose use of the external pins
   input wire logic gpio_p_out,
   input wire logic gpio_n_out,
   input wire logic gpio_oe,
   output logic gpio_p_in,
   output logic gpio_n_in
);

   // ****************************************************************
   // Decoding helpers
   // ****************************************************************
   function automatic logic [5:0] clamp6(input logic [5:0] v,
                                         input logic [5:0] lo,
                                         input logic [5:0] hi);
      if (v < lo) begin
         clamp6 = lo;
      end else if (v > hi) begin
         clamp6 = hi;
      end else begin
         clamp6 = v;
      end
   endfunction : clamp6

   function automatic logic [31:0] fix_div(input logic [31:0] w);
      logic [5:0] h;
      logic [5:0] l;
      logic [6:0] s;
      h = clamp6(w[`PLO_HIGH_LSB +: 6], `PLO_HIGH_MIN, `PLO_N_MAX);
      l = clamp6(w[`PLO_LOW_LSB +: 6], 6'h00, `PLO_LOW_MAX);
      s = {1'b0, h} + {1'b0, l};
      if (s > `PLO_RATIO_MAX) begin
         l = 6'(`PLO_RATIO_MAX - {1'b0, h}); // [RULE23]
      end
      fix_div = 32'h0000_0000;
      fix_div[`PLO_HIGH_LSB +: 6] = h;
      fix_div[`PLO_LOW_LSB +: 6] = l;
      fix_div[`PLO_TAP_LSB +: 3] = w[`PLO_TAP_LSB +: 3];
      fix_div[`PLO_INIT_LSB +: 6] =
         clamp6(w[`PLO_INIT_LSB +: 6], 6'h00, `PLO_LOW_MAX);
   endfunction : fix_div

   function automatic logic [2:0] reg_index(input logic [7:0] a);
      case (a)
         `PLO_ADDR_CTRL: reg_index = 3'h0;
         `PLO_ADDR_DIVIDE: reg_index = 3'h1;
         `PLO_ADDR_DIV_A: reg_index = 3'h2;
         `PLO_ADDR_DIV_B: reg_index = 3'h3;
         `PLO_ADDR_DIV_E: reg_index = 3'h4;
         `PLO_ADDR_STATUS: reg_index = 3'h5;
         default: reg_index = 3'h7;
      endcase
   endfunction : reg_index

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [6:0] pin_raw;
   logic [6:0] pin_v;

   assign pin_raw = {ext_n_in, ext_p_in, detector_gate_enable,
                     counter_resync, run_enable, ref_clk_n, ref_clk_p};

   // A change is taken only when the last two stages agree.
   genvar gs;
   generate
      for (gs = 0; gs < 7; gs++) begin : g_sync
         logic s1;
         logic s2;
         logic s3;
         logic v;
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
               v <= 1'b0;
            end else begin
               s1 <= pin_raw[gs];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3) begin
                  v <= s3;
               end
            end
         end
         assign pin_v[gs] = v;
      end
   endgenerate

   logic run, resync, gate, halt;

   assign run = pin_v[2];
   assign resync = pin_v[3];
   assign gate = pin_v[4];
   assign halt = ~run | resync; // [RULE13] [RULE16]
   assign gpio_p_in = pin_v[5];
   assign gpio_n_in = pin_v[6];

   // ****************************************************************
   // Registers and APB slave
   // ****************************************************************
   logic [31:0] ctrl;
   logic [31:0] divide;
   logic [31:0] div_cfg [3];
   logic [31:0] read_word;
   logic [2:0] idx;
   logic apb_setup;
   logic apb_write;
   plo_loop_type state;
   plo_loop_type next_state;
   logic [7:0] step;
   logic [7:0] fb_cnt;

   assign idx = reg_index(paddr);
   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pwrite & pready;

   always_comb begin
      case (idx)
         3'h0: read_word = ctrl;
         3'h1: read_word = divide;
         3'h2: read_word = div_cfg[0];
         3'h3: read_word = div_cfg[1];
         3'h4: read_word = div_cfg[2];
         3'h5: read_word = {8'h00, fb_cnt, step, 2'h0, state, gate,
                            resync, run, lock};
         default: read_word = 32'h0000_0000;
      endcase
   end

   // The answer is ready in the first access cycle, never later.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup & (idx == 3'h7);
         if (apb_setup) begin
            prdata <= read_word;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= `PLO_CTRL_RESET;
         divide <= `PLO_DIVIDE_RESET;
         div_cfg[0] <= `PLO_DIV_RESET;
         div_cfg[1] <= `PLO_DIV_RESET;
         div_cfg[2] <= `PLO_DIV_RESET;
      end else if (apb_write) begin
         case (idx)
            3'h0: ctrl <= pwdata & `PLO_CTRL_MASK;
            3'h1: begin
               divide <= 32'h0000_0000;
               divide[`PLO_N_LSB +: 6] <= clamp6(pwdata[`PLO_N_LSB +: 6],
                  `PLO_N_MIN, `PLO_N_MAX); // [RULE21]
               divide[`PLO_M_LSB +: 6] <= clamp6(pwdata[`PLO_M_LSB +: 6],
                  `PLO_M_MIN, `PLO_M_MAX); // [RULE22]
            end
            3'h2: div_cfg[0] <= fix_div(pwdata); // [RULE23]
            3'h3: div_cfg[1] <= fix_div(pwdata);
            3'h4: div_cfg[2] <= fix_div(pwdata);
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Reference selection and pre-scale divider
   // ****************************************************************
   logic [5:0] n_val;
   logic [5:0] m_val;
   logic [2:0] fb_tap;
   logic ref_level, ref_prev, ref_rise;
   logic [5:0] ref_cnt;
   logic div_ref_evt;

   assign n_val = divide[`PLO_N_LSB +: 6];
   assign m_val = divide[`PLO_M_LSB +: 6];
   assign fb_tap = ctrl[`PLO_CTRL_FB_TAP_LSB +: 3];
   assign ref_level = ctrl[`PLO_CTRL_REF_DIFF] ?
                      (pin_v[0] & ~pin_v[1]) : pin_v[0]; // [RULE1]
   assign ref_rise = ref_level & ~ref_prev;
   assign div_ref_evt = ref_rise & ~halt &
                        (ref_cnt == n_val - 6'h01); // [RULE20]

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ref_prev <= 1'b0;
         ref_cnt <= 6'h00;
      end else begin
         ref_prev <= ref_level;
         if (halt) begin
            ref_cnt <= 6'h00; // [RULE16]
         end else if (ref_rise) begin
            ref_cnt <= div_ref_evt ? 6'h00 : ref_cnt + 6'h01;
         end
      end
   end

   // ****************************************************************
   // Oscillator with eight phase taps
   // ****************************************************************
   plo_comp_type mode;
   logic [2:0] comp_taps;
   logic [2:0] restart;
   logic [2:0] tap;
   logic [7:0] sub;
   logic [7:0] tap_evt;
   logic fb_evt;
   logic realign;
   logic good;

   assign mode = plo_comp_type'(ctrl[`PLO_CTRL_MODE_LSB +: 2]);

   always_comb begin
      case (mode)
         COMP_ZERO_DELAY: comp_taps = `PLO_EXT_COMP_TAPS; // [RULE3]
         COMP_NORMAL: comp_taps = `PLO_INT_COMP_TAPS; // [RULE4]
         COMP_NONE: comp_taps = 3'h0; // [RULE5]
         default: comp_taps = 3'h0;
      endcase
   end

   assign restart = 3'(comp_taps + fb_tap); // [RULE9]
   assign tap_evt = (sub == 8'h00 && !halt) ? 8'(8'h01 << tap) : 8'h00;
   assign fb_evt = tap_evt[fb_tap]; // [RULE9]

   // A full run of sub through step clocks is one tap step, one eighth of the period.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tap <= 3'h0;
         sub <= 8'h00;
      end else if (halt || realign) begin
         tap <= restart; // [RULE14] [RULE17]
         sub <= 8'h00;
      end else if (sub >= step - 8'h01) begin
         sub <= 8'h00;
         tap <= tap + 3'h1; // [RULE7]
      end else begin
         sub <= sub + 8'h01;
      end
   end

   // ****************************************************************
   // Frequency and phase detection
   // ****************************************************************
   logic good_freq, in_phase;
   logic [3:0] good_cnt;
   logic [11:0] ref_idle;
   logic ref_timeout;

   assign good_freq = (fb_cnt == {2'b00, m_val}); // [RULE20]
   assign in_phase = (tap == restart) || (tap == restart - 3'h1);
   assign good = good_freq & in_phase;
   assign realign = div_ref_evt & gate & ~good; // [RULE18]
   assign ref_timeout = (ref_idle == `PLO_REF_TIMEOUT);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fb_cnt <= 8'h00;
      end else if (halt) begin
         fb_cnt <= 8'h00;
      end else if (div_ref_evt) begin
         fb_cnt <= {7'h00, fb_evt};
      end else if (fb_evt && fb_cnt != 8'hFF) begin
         fb_cnt <= fb_cnt + 8'h01;
      end
   end

   // A phase slip nudges the step by one; a cleared gate freezes it.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         step <= `PLO_STEP_RESET;
      end else if (div_ref_evt && gate) begin // [RULE18]
         if (fb_cnt < {2'b00, m_val} && step > 8'(`PLO_TAP_MIN_CYC)) begin
            step <= step - 8'h01; // [RULE20]
         end else if (fb_cnt > {2'b00, m_val} && step < `PLO_STEP_MAX) begin
            step <= step + 8'h01; // [RULE20]
         end else if (!in_phase && 3'(tap - restart) < 3'h4
                      && step < `PLO_STEP_MAX) begin
            step <= step + 8'h01; // [RULE10]
         end else if (!in_phase && step > 8'(`PLO_TAP_MIN_CYC)) begin
            step <= step - 8'h01; // [RULE10]
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ref_idle <= 12'h000;
      end else if (halt || div_ref_evt) begin
         ref_idle <= 12'h000;
      end else if (!ref_timeout) begin
         ref_idle <= ref_idle + 12'h001;
      end
   end

   // ****************************************************************
   // Lock state machine
   // ****************************************************************
   always_comb begin
      next_state = state;
      case (state)
         LOOP_OFF: begin
            if (!halt) begin
               next_state = LOOP_ACQUIRE; // [RULE14] [RULE17]
            end
         end
         LOOP_ACQUIRE: begin
            if (div_ref_evt && good &&
                good_cnt == `PLO_LOCK_GOOD - 4'h1) begin
               next_state = LOOP_LOCKED; // [RULE10]
            end
         end
         LOOP_LOCKED: begin
            if (ref_timeout || (div_ref_evt && !good)) begin
               next_state = LOOP_ACQUIRE; // [RULE10]
            end
         end
         default: next_state = LOOP_OFF;
      endcase
      if (halt) begin
         next_state = LOOP_OFF; // [RULE13] [RULE16]
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= LOOP_OFF;
         good_cnt <= 4'h0;
         lock <= 1'b0;
      end else begin
         state <= next_state;
         lock <= (next_state == LOOP_LOCKED); // [RULE10]
         if (halt || next_state != LOOP_ACQUIRE) begin
            good_cnt <= 4'h0;
         end else if (div_ref_evt) begin
            good_cnt <= good ? good_cnt + 4'h1 : 4'h0;
         end
      end
   end

   // ****************************************************************
   // Post-scale dividers: A, B global and E external
   // ****************************************************************
   logic [2:0] div_out;
   logic common;

   assign common = ctrl[`PLO_CTRL_COMMON];

   genvar gd;
   generate
      for (gd = 0; gd < 3; gd++) begin : g_div
         logic [2:0] sel_tap;
         logic [5:0] sel_init;
         assign sel_tap = common ? ctrl[`PLO_CTRL_CTAP_LSB +: 3]
                          : div_cfg[gd][`PLO_TAP_LSB +: 3]; // [RULE6] [RULE8]
         assign sel_init = common ? ctrl[`PLO_CTRL_CINIT_LSB +: 5] + 6'h00
                           : div_cfg[gd][`PLO_INIT_LSB +: 6]; // [RULE8]
         plo_divider u_div (
            .clk(clk),
            .sys_rst(sys_rst),
            .clear(halt | realign), // [RULE13] [RULE16]
            .tick(tap_evt[sel_tap]),
            .high_cnt(div_cfg[gd][`PLO_HIGH_LSB +: 6]), // [RULE12]
            .low_cnt(div_cfg[gd][`PLO_LOW_LSB +: 6]),
            .init_cnt(sel_init),
            .clk_out(div_out[gd])
         );
      end
   endgenerate

   assign global_clock_a = div_out[0];
   assign global_clock_b = div_out[1];

   // ****************************************************************
   // External output pins
   // ****************************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_p_out <= 1'b0;
         ext_n_out <= 1'b0;
         ext_p_oe_n <= 1'b1;
         ext_n_oe_n <= 1'b1;
      end else if (ctrl[`PLO_CTRL_EXT_EN]) begin // [RULE2]
         ext_p_out <= div_out[2];
         ext_n_out <= ctrl[`PLO_CTRL_EXT_DIFF] & ~halt & ~div_out[2];
         ext_p_oe_n <= 1'b0;
         ext_n_oe_n <= ~ctrl[`PLO_CTRL_EXT_DIFF];
      end else begin
         ext_p_out <= gpio_p_out; // [RULE2]
         ext_n_out <= gpio_n_out;
         ext_p_oe_n <= ~gpio_oe;
         ext_n_oe_n <= ~gpio_oe;
      end
   end

endmodule : plo_top

// File: verification/plo_ref_model.sv
// Reference clock source driving both reference pins.
`timescale 1ns/10ps
module plo_ref_model #(
   parameter int HALF_NS = 320
) (
   // Control
   input wire logic run,
   // Reference pins
   output logic ref_p,
   output logic ref_n
);
   // The odd start offset keeps reference edges off the system clock edges.
   initial begin
      ref_p = 1'b0;
      #1.3;
      forever begin
         #(HALF_NS);
         if (run) begin
            ref_p = ~ref_p;
         end
      end
   end

   // The pair is complementary, so either pin mode sees a clock.
   assign ref_n = ~ref_p;
endmodule : plo_ref_model

// File: verification/plo_top_assertions.sv
// Checker for the APB handshake and the loop control outputs.
`timescale 1ns/10ps
module plo_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Loop
   input wire logic run_enable,
   input wire logic counter_resync,
   input wire logic global_clock_a,
   input wire logic global_clock_b,
   input wire logic lock
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_setup;
      psel && !penable;
   endsequence
   // Eight cycles cover the input synchroniser plus the clearing edge.
   sequence s_run_off;
      !run_enable [*8];
   endsequence
   sequence s_resync_on;
      counter_resync [*8];
   endsequence
   sequence s_quiet;
      !lock && !global_clock_a && !global_clock_b;
   endsequence
   a_ready_follows: assert property (s_setup |=> pready)
      else $error("pready missing after setup");
   a_ready_single: assert property (pready |-> penable ##1 !pready)
      else $error("pready not a single access pulse");
   a_err_unmapped: assert property (psel && !penable && !pwrite
      && paddr > 8'h14 |=> pslverr && prdata == 32'h0)
      else $error("unmapped read not refused");
   a_mapped_clean: assert property (psel && !penable && paddr <= 8'h14
      && paddr[1:0] == 2'b00 |=> !pslverr)
      else $error("mapped access flagged");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_run_off_quiet: assert property (s_run_off |-> s_quiet)
      else $error("outputs alive with run low");
   a_resync_quiet: assert property (s_resync_on |-> s_quiet)
      else $error("outputs alive during resync");
   a_lock_needs_run: assert property (
      lock |-> $past(run_enable, 8) && !$past(counter_resync, 8))
      else $error("lock without settled run");
endmodule : plo_checker

bind plo_top plo_checker u_plo_checker (.clk(clk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .run_enable(run_enable), .counter_resync(counter_resync),
   .global_clock_a(global_clock_a), .global_clock_b(global_clock_b),
   .lock(lock));

// File: verification/pll_output_control_bench.sv
// Self-checking bench for the loop control block.
`timescale 1ns/10ps
`include "plo_defines.svh"
module pll_output_control_bench;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic ref_p, ref_n, ref_run, run_enable, counter_resync, lock;
   logic detector_gate_enable, global_clock_a, global_clock_b;
   logic ext_p_in, ext_p_out, ext_p_oe_n, ext_n_in, ext_n_out, ext_n_oe_n;
   logic gpio_p_out, gpio_n_out, gpio_oe, gpio_p_in, gpio_n_in, pad_p, pad_n;
   int failures, n_tests, hi, lo, x;

   // Pin level is the design's drive when enabled, else the board's.
   assign ext_p_in = ext_p_oe_n ? pad_p : ext_p_out;
   assign ext_n_in = ext_n_oe_n ? pad_n : ext_n_out;

   plo_ref_model u_plo_ref_model (.run(ref_run), .ref_p(ref_p),
      .ref_n(ref_n));
   plo_top u_plo_top (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ref_clk_p(ref_p), .ref_clk_n(ref_n), .run_enable(run_enable),
      .counter_resync(counter_resync),
      .detector_gate_enable(detector_gate_enable),
      .global_clock_a(global_clock_a), .global_clock_b(global_clock_b),
      .lock(lock), .ext_p_in(ext_p_in), .ext_p_out(ext_p_out),
      .ext_p_oe_n(ext_p_oe_n), .ext_n_in(ext_n_in), .ext_n_out(ext_n_out),
      .ext_n_oe_n(ext_n_oe_n), .gpio_p_out(gpio_p_out),
      .gpio_n_out(gpio_n_out), .gpio_oe(gpio_oe), .gpio_p_in(gpio_p_in),
      .gpio_n_in(gpio_n_in));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ********
   // Tasks
   // ********
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task close_out;
      $display("compares %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   // The leading edge keeps a release and the next request apart.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         failures++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wait_lock(input logic v);
      int k;
      k = 0;
      while (lock !== v && k < 9000) begin
         @(posedge clk);
         k++;
      end
      check(lock, v);
      if (k >= 9000) begin
         close_out();
      end
   endtask : wait_lock

   task wait_b(input logic v, output int n);
      n = 0;
      while (global_clock_b !== v && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 2000) begin
         failures++;
         close_out();
      end
   endtask : wait_b

   // Divider B is high 3, low 1: 192 and 64 clocks at step 8.
   task measure;
      wait_b(1'b0, x);
      wait_b(1'b1, x);
      wait_b(1'b0, hi);
      wait_b(1'b1, lo);
      check(hi, 192);
      check(hi + lo, 256);
   endtask : measure

   // ********
   // Main sequence
   // ********
   initial begin
      sys_rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {run_enable, counter_resync, gpio_p_out, gpio_n_out, gpio_oe} = '0;
      {detector_gate_enable, ref_run, pad_p, pad_n} = 4'hF;
      failures = 0;
      n_tests = 0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, `PLO_ADDR_CTRL, 32'h0);
      check(rd, `PLO_CTRL_RESET);
      apb(1'b0, `PLO_ADDR_DIVIDE, 32'h0);
      check(rd, `PLO_DIVIDE_RESET);
      apb(1'b0, `PLO_ADDR_DIV_E, 32'h0);
      check(rd, `PLO_DIV_RESET);
      apb(1'b0, 8'h18, 32'h0);
      check({err, rd[30:0]}, {1'b1, 31'h0});
      $display("test 1 done");
      apb(1'b1, `PLO_ADDR_DIVIDE, 32'h0000_3F00);
      apb(1'b0, `PLO_ADDR_DIVIDE, 32'h0);
      check(rd, 32'h0000_2001);
      apb(1'b1, `PLO_ADDR_DIVIDE, 32'h0000_013F);
      apb(1'b0, `PLO_ADDR_DIVIDE, 32'h0);
      check(rd, 32'h0000_0220);
      apb(1'b1, `PLO_ADDR_DIV_A, 32'h3F3F_3F3F);
      apb(1'b0, `PLO_ADDR_DIV_A, 32'h0);
      check(rd, 32'h1F07_0020);
      apb(1'b1, `PLO_ADDR_DIVIDE, `PLO_DIVIDE_RESET);
      apb(1'b1, `PLO_ADDR_DIV_A, `PLO_DIV_RESET);
      apb(1'b1, `PLO_ADDR_DIV_B, 32'h0000_0103);
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, `PLO_ADDR_CTRL, 32'h001F_7720 | (32'(i) << 3));
         apb(1'b0, `PLO_ADDR_CTRL, 32'h0);
         check(rd, 32'h001F_7720 | (32'(i) << 3));
      end
      apb(1'b1, `PLO_ADDR_CTRL, `PLO_CTRL_RESET);
      $display("test 2 done");
      run_enable <= 1'b1;
      wait_lock(1'b1);
      apb(1'b0, `PLO_ADDR_STATUS, 32'h0);
      check(rd[5:0], 6'h2B);
      measure();
      $display("test 3 done");
      apb(1'b1, `PLO_ADDR_CTRL, 32'h0000_0009);
      repeat (3) @(posedge clk);
      check({ext_p_oe_n, ext_n_oe_n}, 2'b01);
      apb(1'b1, `PLO_ADDR_CTRL, 32'h0000_000B);
      repeat (3) @(posedge clk);
      check({ext_p_oe_n, ext_n_oe_n, ext_n_out ^ ext_p_out}, 1);
      apb(1'b1, `PLO_ADDR_CTRL, `PLO_CTRL_RESET);
      gpio_oe <= 1'b1;
      gpio_p_out <= 1'b1;
      repeat (4) @(posedge clk);
      check({ext_p_out, ext_p_oe_n, ext_n_out, ext_n_oe_n}, 4'h8);
      gpio_oe <= 1'b0;
      pad_p <= 1'b0;
      repeat (6) @(posedge clk);
      check({gpio_p_in, gpio_n_in}, 2'b01);
      $display("test 4 done");
      // Lock is only trusted as a gate after it settles in wait_lock.
      detector_gate_enable <= 1'b0;
      ref_run <= 1'b0;
      measure();
      wait_lock(1'b0);
      ref_run <= 1'b1;
      detector_gate_enable <= 1'b1;
      wait_lock(1'b1);
      $display("test 5 done");
      run_enable <= 1'b0;
      repeat (12) @(posedge clk);
      check({lock, global_clock_a, global_clock_b}, 3'b000);
      run_enable <= 1'b1;
      wait_lock(1'b1);
      counter_resync <= 1'b1;
      repeat (20) @(posedge clk);
      check({lock, global_clock_a, global_clock_b}, 3'b000);
      counter_resync <= 1'b0;
      wait_lock(1'b1);
      measure();
      $display("test 6 done");
      close_out();
   end
endmodule : pll_output_control_bench
